// file: core/pps_defs.svh
// constants of the pll phase step and bypass controller
// assumes inclusion by bare name from the package and the design file
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
// divider setting layout: bypass flag in the top bit of nine
`define PPS_SET_W 9
`define PPS_BYP_BIT 8
`define PPS_SET_RST 9'h100
`define PPS_FACTOR_ONE 9'h001
`define PPS_FACTOR_MAX 9'h100
// apb byte offsets, one aligned word each
`define PPS_OFF_DIV_BASE 8'h00
`define PPS_OFF_TAP 8'h20
`define PPS_OFF_STEPS 8'h24
`define PPS_WORD_DIVS 6'h00
`define PPS_WORD_TAP 6'h08
`define PPS_WORD_STEPS 6'h09
// divider slots in the setting table
`define PPS_IDX_PRE 0
`define PPS_IDX_FB 1
`define PPS_IDX_OUT0 2
// counter-select codes
`define PPS_SEL_ALL 3'h0
`define PPS_SEL_FB 3'h1
`define PPS_SEL_OUT0 3'h2
// one tap is one eighth of the oscillator period
`define PPS_TAP_W 3
`define PPS_TAP_ONE 3'h1
`define PPS_TAP_RST 3'h0
`define PPS_STEPS_W 16
`endif

// file: core/pps_pkg.sv
// types of the pll phase step and bypass controller
// assumes pps_defs.svh is on the include path
`include "pps_defs.svh"
package pps_pkg;
   // one divider setting: bypass flag above the divide value
   typedef struct packed {
      logic bypass;
      logic [7:0] value;
   } pps_div_type;
   // one phase step request as captured from the fabric
   typedef struct packed {
      logic [2:0] sel;
      logic up;
   } pps_cmd_type;
   // step sequencer, gray coded along idle, apply, hold
   typedef enum logic [1:0] {
      PPS_IDLE = 2'b00,
      PPS_APPLY = 2'b01,
      PPS_HOLD = 2'b11
   } pps_state_type;
endpackage

// file: core/pps_phase_ctrl.sv
// pll runtime control: divider bypass settings over apb and dynamic phase stepping
// assumes mclk is the reconfiguration clock and the step controls come from fabric
// logic on that clock; an apb master drives the register port
//
// Contract
// - bypassed divider divides by exactly one
// - bypass flag set ignores all other bits
// - bypass flag is top bit; zero means normal
// - phase moves by tap shift, no scan data
// - each step moves one eighth oscillator period
// - output clocks keep running during steps
// - three-bit select picks feedback, output, or all
// - select captured on reconfiguration clock rising edge
// - direction one is later, zero is earlier
// - direction captured on reconfiguration clock rising edge
// - phase adjusts only while step strobe high
`include "pps_defs.svh"
module pps_phase_ctrl
   import pps_pkg::*;
#(
   parameter int NUM_OUT = 5
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] phaseCounterSelect,
   input wire logic phaseUpDown,
   input wire logic phaseStep,
   output logic [8:0] prescaleFactor,
   output logic [8:0] feedbackFactor,
   output logic [NUM_OUT-1:0][8:0] outFactor,
   output logic [2:0] feedbackTap,
   output logic [NUM_OUT-1:0][2:0] outTap,
   output logic stepDone
);
   localparam int NDIV = NUM_OUT + 2; // prescale, feedback, outputs
   // the select code has room for six output dividers; the check allows five
   if (NUM_OUT < 1 || NUM_OUT > 5)
   begin : g_badParam
      $error("pps_phase_ctrl: NUM_OUT must be 1 to 5");
   end

   // ---------------- apb slave ----------------
   logic [5:0] word; // word index of the address
   logic wrEn; // write takes effect this edge
   logic rdSetup; // setup cycle of any transfer, read or write
   logic mapped; // address hits a register
   logic [31:0] rdData; // read mux result
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;

   assign word = paddr[7:2];
   // zero wait states, so the access phase is always the last
   assign pready = psel & penable;
   assign wrEn = psel & penable & pwrite & mapped;
   assign rdSetup = psel & ~penable;
   assign mapped = (word < 6'(NDIV)) || (word == `PPS_WORD_TAP)
      || (word == `PPS_WORD_STEPS);
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg & pready;
   // ---------------- divider settings ----------------
   pps_div_type divSet_reg [NDIV]; // nine-bit setting per divider
   pps_div_type divSet_next [NDIV];
   logic [8:0] factor_reg [NDIV]; // effective divide factor
   logic [8:0] factor_next [NDIV];

   // settings: apb writes land here, only the low nine bits count;
   // factors follow the new settings so they never lag a write
   always_comb
   begin
      for (int i = 0; i < NDIV; i++)
      begin
         divSet_next[i] = divSet_reg[i];
         if (wrEn && word == 6'(i))
         begin
            divSet_next[i] = pps_div_type'(pwdata[`PPS_SET_W-1:0]);
         end
         if (divSet_next[i].bypass)
         begin
            // flag set: value bits ignored, divide by one
            factor_next[i] = `PPS_FACTOR_ONE;
         end
         else if (divSet_next[i].value == 8'h00)
         begin
            // zero value taken as the largest count
            factor_next[i] = `PPS_FACTOR_MAX;
         end
         else
         begin
            factor_next[i] = {1'b0, divSet_next[i].value};
         end
      end
   end

   // settings and factors; reset leaves every divider bypassed
   always_ff @(posedge mclk)
   begin
      for (int i = 0; i < NDIV; i++)
      begin
         if (srst)
         begin
            divSet_reg[i] <= pps_div_type'(`PPS_SET_RST);
            factor_reg[i] <= `PPS_FACTOR_ONE;
         end
         else
         begin
            divSet_reg[i] <= divSet_next[i];
            factor_reg[i] <= factor_next[i];
         end
      end
   end

   assign prescaleFactor = factor_reg[`PPS_IDX_PRE];
   assign feedbackFactor = factor_reg[`PPS_IDX_FB];
   // ---------------- phase step sequencer ----------------
   pps_state_type state_reg; // step sequencer state
   pps_state_type state_next;
   pps_cmd_type cmd_reg; // captured select and direction
   pps_cmd_type cmd_next;
   logic [2:0] fbTap_reg; // feedback tap, eighths of a period
   logic [2:0] fbTap_next;
   logic [2:0] outTap_reg [NUM_OUT]; // output taps
   logic [2:0] outTap_next [NUM_OUT];
   logic [15:0] steps_reg; // steps done since reset
   logic [15:0] steps_next;
   logic done_reg;
   logic done_next;

   // one step per strobe: capture, apply once, wait for release
   always_comb
   begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      case (state_reg)
         PPS_IDLE:
         begin
            if (phaseStep)
            begin
               // select and direction taken on this rising edge
               cmd_next = '{sel: phaseCounterSelect, up: phaseUpDown};
               state_next = PPS_APPLY;
            end
         end
         PPS_APPLY:
         begin
            state_next = PPS_HOLD;
         end
         PPS_HOLD:
         begin
            // a held strobe gives no second step
            if (!phaseStep)
            begin
               state_next = PPS_IDLE;
            end
         end
         default:
         begin
            state_next = PPS_IDLE;
         end
      endcase
   end
   // tap moves; only the tap select changes, never the divider
   // counts, so clocks keep toggling through a step
   always_comb
   begin
      logic [2:0] delta;
      delta = cmd_reg.up ? `PPS_TAP_ONE : 3'(-`PPS_TAP_ONE);
      fbTap_next = fbTap_reg;
      steps_next = steps_reg;
      done_next = 1'b0;
      for (int i = 0; i < NUM_OUT; i++)
      begin
         outTap_next[i] = outTap_reg[i];
      end
      if (state_reg == PPS_APPLY)
      begin
         done_next = 1'b1;
         steps_next = steps_reg + 16'h0001;
         if (cmd_reg.sel == `PPS_SEL_FB)
         begin
            fbTap_next = fbTap_reg + delta;
         end
         for (int i = 0; i < NUM_OUT; i++)
         begin
            // code zero moves every output together
            if (cmd_reg.sel == `PPS_SEL_ALL || cmd_reg.sel == 3'(`PPS_SEL_OUT0 + i))
            begin
               outTap_next[i] = outTap_reg[i] + delta;
            end
         end
      end
   end
   // sequencer registers
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_reg <= PPS_IDLE;
         cmd_reg <= '0;
         fbTap_reg <= `PPS_TAP_RST;
         steps_reg <= '0;
         done_reg <= 1'b0;
         for (int i = 0; i < NUM_OUT; i++)
         begin
            outTap_reg[i] <= `PPS_TAP_RST;
         end
      end
      else
      begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         fbTap_reg <= fbTap_next;
         steps_reg <= steps_next;
         done_reg <= done_next;
         for (int i = 0; i < NUM_OUT; i++)
         begin
            outTap_reg[i] <= outTap_next[i];
         end
      end
   end
   assign feedbackTap = fbTap_reg;
   assign stepDone = done_reg;
   for (genvar g = 0; g < NUM_OUT; g++)
   begin : g_outTap
      assign outTap[g] = outTap_reg[g];
      assign outFactor[g] = factor_reg[`PPS_IDX_OUT0 + g];
   end
   // ---------------- read path ----------------
   // read mux; taps packed three bits each, feedback lowest
   always_comb
   begin
      rdData = '0;
      if (word < 6'(NDIV))
      begin
         rdData[`PPS_SET_W-1:0] = divSet_reg[word[2:0]];
      end
      else if (word == `PPS_WORD_TAP)
      begin
         rdData[2:0] = fbTap_reg;
         for (int i = 0; i < NUM_OUT; i++)
         begin
            rdData[3*i+3 +: 3] = outTap_reg[i];
         end
      end
      else if (word == `PPS_WORD_STEPS)
      begin
         rdData[`PPS_STEPS_W-1:0] = steps_reg;
      end
   end

   // read data is latched in setup so it comes from a flop
   always_comb
   begin
      prdata_next = prdata_reg;
      pslverr_next = pslverr_reg;
      if (rdSetup)
      begin
         prdata_next = pwrite ? 32'h0000_0000 : rdData;
         pslverr_next = ~mapped;
      end
   end
   // apb answer registers
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end
   // ---------------- assertions ----------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   property p_bypassOne;
      divSet_reg[`PPS_IDX_PRE].bypass |-> prescaleFactor == `PPS_FACTOR_ONE;
   endproperty
   a_bypassOne: assert property (p_bypassOne) else $error("bypass not one");
   property p_flagWins;
      (wrEn && word == 6'(`PPS_IDX_FB) && pwdata[`PPS_BYP_BIT])
         |=> feedbackFactor == `PPS_FACTOR_ONE;
   endproperty
   a_flagWins: assert property (p_flagWins) else $error("flag not honoured");
   property p_normal;
      (!divSet_reg[`PPS_IDX_PRE].bypass && divSet_reg[`PPS_IDX_PRE].value != 8'h00)
         |-> prescaleFactor == {1'b0, divSet_reg[`PPS_IDX_PRE].value};
   endproperty
   a_normal: assert property (p_normal) else $error("normal divide wrong");
   property p_fbUp;
      (state_reg == PPS_APPLY && cmd_reg.sel == `PPS_SEL_FB && cmd_reg.up)
         |=> feedbackTap == 3'($past(feedbackTap) + 3'h1);
   endproperty
   a_fbUp: assert property (p_fbUp) else $error("tap up wrong");
   property p_outDown;
      (state_reg == PPS_APPLY && cmd_reg.sel == `PPS_SEL_OUT0 && !cmd_reg.up)
         |=> outTap[0] == 3'($past(outTap[0]) - 3'h1);
   endproperty
   a_outDown: assert property (p_outDown) else $error("tap down wrong");
   property p_factorsSteady;
      (state_reg == PPS_APPLY && !wrEn) |=> $stable(feedbackFactor) && $stable(prescaleFactor);
   endproperty
   a_factorsSteady: assert property (p_factorsSteady) else $error("step hit a divider");
   property p_allMove;
      (state_reg == PPS_APPLY && cmd_reg.sel == `PPS_SEL_ALL)
         |=> outTap[NUM_OUT-1] != $past(outTap[NUM_OUT-1]) && $stable(feedbackTap);
   endproperty
   a_allMove: assert property (p_allMove) else $error("all-select wrong");
   property p_capture;
      (state_reg == PPS_IDLE && phaseStep)
         |=> cmd_reg == {$past(phaseCounterSelect), $past(phaseUpDown)};
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");
   property p_strobeOnly;
      stepDone |-> $past(phaseStep, 2);
   endproperty
   a_strobeOnly: assert property (p_strobeOnly) else $error("step without strobe");
endmodule

// file: bench/pps_fabric_model.sv
// fabric-side model that drives the phase step controls
// assumes mclk is the reconfiguration clock and stepDone comes from the controller
module pps_fabric_model
   import pps_pkg::*;
(
   input wire logic mclk,
   input wire logic stepDone,
   output logic [2:0] phaseCounterSelect,
   output logic phaseUpDown,
   output logic phaseStep
);
   timeunit 1ns;
   timeprecision 1ps;
   // strobe low from time zero
   initial
   begin
      phaseCounterSelect = 3'h7;
      phaseUpDown = 1'b0;
      phaseStep = 1'b0;
   end
   // one step: select and direction stand with the strobe until done
   task automatic step(input pps_cmd_type cmd, input int extra);
      @(posedge mclk);
      phaseCounterSelect <= cmd.sel;
      phaseUpDown <= cmd.up;
      phaseStep <= 1'b1;
      do @(posedge mclk); while (stepDone !== 1'b1);
      // extra high time checks that a long strobe is still one step
      repeat (extra) @(posedge mclk);
      phaseStep <= 1'b0;
      // released lines show the inverse, not the old value
      phaseCounterSelect <= ~cmd.sel;
      phaseUpDown <= ~cmd.up;
      @(posedge mclk); // low for at least one edge
   endtask
endmodule

// file: bench/test_pll_phase_step_and_bypass.sv
// self-checking bench for the phase step and bypass controller
// assumes the controller package and defines header are compiled first
`include "pps_defs.svh"
module test_pll_phase_step_and_bypass
   import pps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, srst, psel, penable, pwrite, pready, pslverr, stepDone;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] phaseCounterSelect, feedbackTap;
   logic phaseUpDown, phaseStep, err;
   logic [8:0] prescaleFactor, feedbackFactor;
   logic [4:0][8:0] outFactor;
   logic [4:0][2:0] outTap;
   logic [2:0] tapExp [6]; // slot 0 feedback, 1..5 outputs
   logic [8:0] facExp [7]; // prescale, feedback, outputs
   logic [15:0] stepCnt;
   int badCount = 0;
   int checks = 0;
   pps_phase_ctrl #(.NUM_OUT(5)) dut (.mclk(mclk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phaseCounterSelect(phaseCounterSelect), .phaseUpDown(phaseUpDown),
      .phaseStep(phaseStep), .prescaleFactor(prescaleFactor),
      .feedbackFactor(feedbackFactor), .outFactor(outFactor),
      .feedbackTap(feedbackTap), .outTap(outTap), .stepDone(stepDone));
   pps_fabric_model fab (.mclk(mclk), .stepDone(stepDone),
      .phaseCounterSelect(phaseCounterSelect), .phaseUpDown(phaseUpDown),
      .phaseStep(phaseStep));
   // 100 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic completeRun();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // compare every factor and tap against the expected tables
   task automatic cmpAll();
      // factors written at the last rising edge settle only after it
      @(negedge mclk);
      chk("prescale", prescaleFactor, facExp[0]);
      chk("feedback", feedbackFactor, facExp[1]);
      chk("fbtap", feedbackTap, tapExp[0]);
      for (int i = 0; i < 5; i++)
      begin
         chk("outfac", outFactor[i], facExp[i+2]);
         chk("outtap", outTap[i], tapExp[i+1]);
      end
   endtask
   task automatic t_reset();
      cmpAll();
      chk("done", stepDone, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      chk("setting", rd, 32'h100);
   endtask
   // each divider: bypass with junk bits, then a plain value and readback; prescale then zero
   task automatic t_bypass();
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, 8'(4 * i), 32'hffff_ffff);
         facExp[i] = 9'h001;
         cmpAll(); // bypass ignores every other bit
         apb(1'b1, 8'(4 * i), 32'(i + 3));
         facExp[i] = 9'(i + 3);
         cmpAll();
         apb(1'b0, 8'(4 * i), 32'h0);
         chk("readback", rd, 32'(i + 3));
      end
      apb(1'b1, 8'h00, 32'h0);
      facExp[0] = 9'h100;
      cmpAll();
   endtask
   task automatic t_refuse();
      apb(1'b1, 8'h40, 32'h1);
      chk("wrerr", err, 1'b1);
      apb(1'b1, 8'h20, 32'hff);
      chk("tapro", err, 1'b0);
      apb(1'b0, 8'h20, 32'h0);
      chk("taprd", rd, 32'h0);
   endtask
   // one step through the model, then compare taps, count and factors
   task automatic doStep(input logic [2:0] sel, input logic up, input int extra);
      logic [2:0] d;
      d = up ? 3'h1 : 3'h7;
      fab.step('{sel: sel, up: up}, extra);
      stepCnt++;
      if (sel == 3'h1)
         tapExp[0] += d;
      else if (sel == 3'h0)
         for (int i = 1; i < 6; i++)
            tapExp[i] += d;
      else if (sel != 3'h7)
         tapExp[sel-1] += d;
      cmpAll();
      apb(1'b0, 8'h24, 32'h0);
      chk("steps", rd, 32'(stepCnt));
   endtask
   task automatic t_steps();
      for (int s = 0; s < 8; s++)
         doStep(3'(s), 1'b1, 0);
      doStep(3'h1, 1'b0, 0);
      doStep(3'h1, 1'b0, 0);
      doStep(3'h0, 1'b0, 0);
   endtask
   task automatic t_hold();
      doStep(3'h4, 1'b1, 6);
      apb(1'b0, 8'h20, 32'h0);
      chk("tapword", rd[8:6], tapExp[2]);
      chk("tapheld", rd[11:9], tapExp[3]);
   endtask
   initial
   begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      stepCnt = 16'h0;
      for (int i = 0; i < 7; i++)
         facExp[i] = 9'h001;
      for (int i = 0; i < 6; i++)
         tapExp[i] = 3'h0;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_bypass();
      t_refuse();
      t_steps();
      t_hold();
      completeRun();
   end
   // watchdog: far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge mclk);
      badCount++;
      completeRun();
   end
endmodule
